/* File: bridge_pkg.sv */
// constants shared by the map cache bridge and its cache array
// ==========================================================
// Overview of operation
// [RULE1] a valid cached entry matching the page translates the address
// [RULE2] invalid or missing entry starts a fetch of the map register
// [RULE3] flags clear on reset, invalidate, io reset, base or map write
// [RULE4] sixteen entries each hold address bits 21..9 as a matched tag
// [RULE5] a valid hit supplies the 20-bit page as memory bits 28..9
// [RULE6] backplane bits 8..0 pass unchanged as memory bits 8..0
// [RULE7] local io window becomes a backplane io cycle with io page select
// [RULE8] io cycles drive backplane address bits 21..13 as zeros
// [RULE9] local memory window becomes a memory cycle copying bits 21..0
// [RULE10] comm register is 16 bits, reachable from both buses, byte writable
// [RULE11] comm register at 1000_1f40, 2000_1f40 and backplane 17777500 octal
// [RULE12] dma memory error flag sets on error register bit 4 or bus timeout
// [RULE13] flag clears on write one, reset, io reset, or error bit falling
// [RULE14] bit 14 write one invalidates every entry, reads zero
// [RULE15] bits 13..9 read zero; software writes zeros there
// [RULE16] refills replace entries in first-in first-out order
// [RULE17] fetch via the map base; entry cached only if its valid bit is set
// [RULE18] writing zero to the error flag leaves it unchanged
`default_nettype none
package bridge_pkg;
	// ==========================================================
	// cache geometry
	localparam int ENTRIES = 16;
	localparam int TAG_W = 13;
	localparam int PAGE_W = 20;
	localparam int BP_W = 22;
	localparam int MEM_W = 29;
	localparam int OFS_W = 9;
	localparam int BASE_LSB = 15;
	// ==========================================================
	// local cpu bus windows, compared on the high address bits
	localparam int IO_LSB = 13;
	localparam logic [18:0] IO_CPU = 19'h0_8000;
	localparam logic [18:0] IO_DIAG = 19'h1_0000;
	localparam int MEMW_LSB = 22;
	localparam logic [9:0] MEM_CPU = 10'h050;
	localparam logic [9:0] MEM_DIAG = 10'h0c0;
	// ==========================================================
	// communication register locations and fields
	localparam logic [31:0] COMM_CPU = 32'h1000_1f40;
	localparam logic [31:0] COMM_DIAG = 32'h2000_1f40;
	localparam logic [21:0] COMM_BP = 22'h3f_ff40;
	localparam int ERR_BIT = 15;
	localparam int INVAL_BIT = 14;
	localparam logic [15:0] COMM_RESET = 16'h0000;
	// ==========================================================
	// fetched map word layout
	localparam int MAP_VALID_BIT = 31;
endpackage
`default_nettype wire

/* File: map_cache.sv */
// sixteen entry associative page map cache with fifo refill
`default_nettype none
module map_cache
	import bridge_pkg::*;
#(
	parameter int N = ENTRIES
)(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [TAG_W-1:0] look_tag_in,
	output logic hit_out,
	output logic [PAGE_W-1:0] hit_page_out,
	input wire logic fill_in,
	input wire logic [TAG_W-1:0] fill_tag_in,
	input wire logic [PAGE_W-1:0] fill_page_in,
	input wire logic inval_all_in,
	input wire logic inval_one_in,
	input wire logic [TAG_W-1:0] inval_tag_in
);
	localparam int PW = $clog2(N);
	logic [TAG_W-1:0] tag_r [N];
	logic [PAGE_W-1:0] page_r [N];
	logic [N-1:0] valid_r, valid_nxt, match;
	logic [PW-1:0] ptr_r, ptr_nxt;

	// ==========================================================
	// per entry compare
	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_ent
			assign match[g] = valid_r[g] && tag_r[g] == look_tag_in; // [RULE4]
		end
	endgenerate

	always_comb
	begin
		hit_out = |match; // [RULE1]
		hit_page_out = '0;
		for (int i = 0; i < N; i++)
		begin
			if (match[i])
				hit_page_out = page_r[i];
		end
	end

	// ==========================================================
	// valid flags and refill pointer
	always_comb
	begin
		valid_nxt = valid_r;
		ptr_nxt = ptr_r;
		for (int i = 0; i < N; i++)
		begin
			// a stale copy must never survive a map change
			if (inval_one_in && tag_r[i] == inval_tag_in)
				valid_nxt[i] = 1'b0; // [RULE3]
		end
		if (inval_all_in)
			valid_nxt = '0; // [RULE3]
		// a fill in the invalidating cycle still lands: set wins
		if (fill_in)
		begin
			valid_nxt[ptr_r] = 1'b1;
			ptr_nxt = ptr_r + 1'b1; // [RULE16]
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			valid_r <= '0; // [RULE3]
			ptr_r <= '0;
		end
		else
		begin
			valid_r <= valid_nxt;
			ptr_r <= ptr_nxt;
		end
	end

	// tag and page storage needs no reset; valid guards it
	always_ff @(posedge clk_in)
	begin
		if (fill_in)
		begin
			tag_r[ptr_r] <= fill_tag_in;
			page_r[ptr_r] <= fill_page_in;
		end
	end
endmodule
`default_nettype wire

/* File: backplane_map_cache_bridge.sv */
// address translation, map cache control and communication register
`default_nettype none
module backplane_map_cache_bridge
	import bridge_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic dc_power_good_in,
	input wire logic halted_in,
	// backplane dma translation
	input wire logic bp_req_in,
	input wire logic [bridge_pkg::BP_W-1:0] bp_addr_in,
	output logic bp_done_out,
	output logic bp_mapped_out,
	output logic [bridge_pkg::MEM_W-1:0] bp_mem_addr_out,
	// map register fetch from local memory
	input wire logic [bridge_pkg::MEM_W-1:bridge_pkg::BASE_LSB] map_base_in,
	output logic map_fetch_req_out,
	output logic [bridge_pkg::MEM_W-1:0] map_fetch_addr_out,
	input wire logic map_fetch_done_in,
	input wire logic [31:0] map_fetch_data_in,
	// invalidating events
	input wire logic io_reset_write_in,
	input wire logic map_base_write_in,
	input wire logic page_map_write_in,
	input wire logic [bridge_pkg::TAG_W-1:0] page_map_write_tag_in,
	// error sources
	input wire logic dma_error_mem_bit_in,
	input wire logic bus_timer_expired_in,
	// local cpu bus
	input wire logic cpu_req_in,
	input wire logic cpu_wr_in,
	input wire logic [31:0] cpu_addr_in,
	input wire logic [1:0] cpu_be_in,
	input wire logic [15:0] cpu_wdata_in,
	output logic cpu_ack_out,
	output logic [15:0] cpu_rdata_out,
	output logic cpu_bp_cycle_out,
	output logic io_page_select_out,
	output logic [bridge_pkg::BP_W-1:0] cpu_bp_addr_out,
	// backplane slave access to the communication register
	input wire logic bp_reg_req_in,
	input wire logic bp_reg_wr_in,
	input wire logic [bridge_pkg::BP_W-1:0] bp_reg_addr_in,
	input wire logic [1:0] bp_reg_be_in,
	input wire logic [15:0] bp_reg_wdata_in,
	output logic bp_reg_ack_out,
	output logic [15:0] bp_reg_rdata_out
);
	import bridge_pkg::*;

	typedef enum logic {ST_IDLE, ST_FETCH} xlate_state_t;

	// ==========================================================
	// power good synchroniser; stages two and three feed the edge check
	logic pg1_r, pg2_r, pg3_r, pg1_nxt, pg2_nxt, pg3_nxt, dc_clr;
	always_comb
	begin
		pg1_nxt = dc_power_good_in;
		pg2_nxt = pg1_r;
		pg3_nxt = pg2_r;
		dc_clr = pg3_r && !pg2_r && halted_in; // [RULE3] [RULE13]
	end
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			pg1_r <= 1'b1;
			pg2_r <= 1'b1;
			pg3_r <= 1'b1;
		end
		else
		begin
			pg1_r <= pg1_nxt;
			pg2_r <= pg2_nxt;
			pg3_r <= pg3_nxt;
		end
	end

	// ==========================================================
	// communication register access decode
	logic cpu_comm, bp_comm, cpu_io, cpu_mem;
	logic err_w1c, inval_w1, err_clr, err_set;
	logic err_r, err_nxt, dma_error_register_r, dma_error_register_nxt;
	logic [15:0] comm_rd;
	always_comb
	begin
		cpu_comm = cpu_req_in &&
			(cpu_addr_in == COMM_CPU || cpu_addr_in == COMM_DIAG); // [RULE11]
		bp_comm = bp_reg_req_in && bp_reg_addr_in == COMM_BP; // [RULE11]
		// only the high byte holds live bits; low byte writes land nowhere
		err_w1c = (cpu_comm && cpu_wr_in && cpu_be_in[1] &&
			cpu_wdata_in[ERR_BIT]) ||
			(bp_comm && bp_reg_wr_in && bp_reg_be_in[1] &&
			bp_reg_wdata_in[ERR_BIT]); // [RULE10] [RULE18]
		inval_w1 = (cpu_comm && cpu_wr_in && cpu_be_in[1] &&
			cpu_wdata_in[INVAL_BIT]) ||
			(bp_comm && bp_reg_wr_in && bp_reg_be_in[1] &&
			bp_reg_wdata_in[INVAL_BIT]); // [RULE14]
		dma_error_register_nxt = dma_error_mem_bit_in;
		err_set = dma_error_mem_bit_in || bus_timer_expired_in; // [RULE12]
		err_clr = err_w1c || io_reset_write_in || dc_clr ||
			(dma_error_register_r && !dma_error_mem_bit_in); // [RULE13]
		err_nxt = err_r;
		if (err_clr)
			err_nxt = 1'b0;
		// a new error in the clearing cycle must not be lost
		if (err_set)
			err_nxt = 1'b1;
		comm_rd = COMM_RESET;
		comm_rd[ERR_BIT] = err_r; // [RULE14] [RULE15]
	end
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			err_r <= 1'b0; // [RULE13]
			dma_error_register_r <= 1'b0;
		end
		else
		begin
			err_r <= err_nxt;
			dma_error_register_r <= dma_error_register_nxt;
		end
	end

	// ==========================================================
	// register answers on both buses and local cpu outbound translation
	logic cpu_ack_nxt, bp_reg_ack_nxt, cpu_bp_cycle_nxt, io_sel_nxt;
	logic [15:0] cpu_rdata_nxt, bp_reg_rdata_nxt;
	logic [BP_W-1:0] cpu_bp_addr_nxt;
	always_comb
	begin
		cpu_io = cpu_addr_in[31:IO_LSB] == IO_CPU ||
			cpu_addr_in[31:IO_LSB] == IO_DIAG;
		cpu_mem = cpu_addr_in[31:MEMW_LSB] == MEM_CPU ||
			cpu_addr_in[31:MEMW_LSB] == MEM_DIAG;
		cpu_ack_nxt = cpu_comm;
		cpu_rdata_nxt = cpu_comm ? comm_rd : 16'h0000;
		bp_reg_ack_nxt = bp_comm;
		bp_reg_rdata_nxt = bp_comm ? comm_rd : 16'h0000;
		cpu_bp_cycle_nxt = cpu_req_in && !cpu_comm && (cpu_io || cpu_mem);
		io_sel_nxt = io_page_select_out;
		cpu_bp_addr_nxt = cpu_bp_addr_out;
		if (cpu_req_in && !cpu_comm && cpu_io)
		begin
			io_sel_nxt = 1'b1; // [RULE7]
			cpu_bp_addr_nxt = {{(BP_W-IO_LSB){1'b0}},
				cpu_addr_in[IO_LSB-1:0]}; // [RULE7] [RULE8]
		end
		else if (cpu_req_in && cpu_mem)
		begin
			io_sel_nxt = 1'b0;
			cpu_bp_addr_nxt = cpu_addr_in[BP_W-1:0]; // [RULE9]
		end
	end
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			cpu_ack_out <= 1'b0;
			cpu_rdata_out <= 16'h0000;
			bp_reg_ack_out <= 1'b0;
			bp_reg_rdata_out <= 16'h0000;
			cpu_bp_cycle_out <= 1'b0;
			io_page_select_out <= 1'b0;
			cpu_bp_addr_out <= '0;
		end
		else
		begin
			cpu_ack_out <= cpu_ack_nxt;
			cpu_rdata_out <= cpu_rdata_nxt;
			bp_reg_ack_out <= bp_reg_ack_nxt;
			bp_reg_rdata_out <= bp_reg_rdata_nxt;
			cpu_bp_cycle_out <= cpu_bp_cycle_nxt;
			io_page_select_out <= io_sel_nxt;
			cpu_bp_addr_out <= cpu_bp_addr_nxt;
		end
	end

	// ==========================================================
	// inbound dma translation through the map cache
	xlate_state_t st_r, st_nxt;
	logic [BP_W-1:0] req_addr_r, req_addr_nxt;
	logic hit, fill, done_nxt, mapped_nxt, fetch_nxt;
	logic [PAGE_W-1:0] hit_page;
	logic [MEM_W-1:0] mem_addr_nxt, fetch_addr_nxt;
	logic [TAG_W-1:0] look_tag;

	map_cache #(.N(ENTRIES)) u_cache (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.look_tag_in(look_tag),
		.hit_out(hit),
		.hit_page_out(hit_page),
		.fill_in(fill),
		.fill_tag_in(req_addr_r[BP_W-1:OFS_W]),
		.fill_page_in(map_fetch_data_in[PAGE_W-1:0]),
		.inval_all_in(inval_w1 || io_reset_write_in ||
			map_base_write_in || dc_clr), // [RULE3]
		.inval_one_in(page_map_write_in), // [RULE3]
		.inval_tag_in(page_map_write_tag_in)
	);

	always_comb
	begin
		look_tag = bp_addr_in[BP_W-1:OFS_W];
		st_nxt = st_r;
		req_addr_nxt = req_addr_r;
		fill = 1'b0;
		done_nxt = 1'b0;
		mapped_nxt = bp_mapped_out;
		mem_addr_nxt = bp_mem_addr_out;
		fetch_nxt = map_fetch_req_out;
		fetch_addr_nxt = map_fetch_addr_out;
		unique case (st_r)
			ST_IDLE:
			begin
				if (bp_req_in && hit)
				begin
					done_nxt = 1'b1;
					mapped_nxt = 1'b1; // [RULE1]
					mem_addr_nxt = {hit_page,
						bp_addr_in[OFS_W-1:0]}; // [RULE5] [RULE6]
				end
				else if (bp_req_in)
				begin
					req_addr_nxt = bp_addr_in;
					fetch_nxt = 1'b1; // [RULE2]
					// the map is an 8k word block; one word per page
					fetch_addr_nxt = {map_base_in,
						bp_addr_in[BP_W-1:OFS_W], 2'b00}; // [RULE17]
					st_nxt = ST_FETCH;
				end
			end
			ST_FETCH:
			begin
				if (map_fetch_done_in)
				begin
					fetch_nxt = 1'b0;
					done_nxt = 1'b1;
					fill = map_fetch_data_in[MAP_VALID_BIT]; // [RULE17]
					mapped_nxt = map_fetch_data_in[MAP_VALID_BIT];
					mem_addr_nxt = {map_fetch_data_in[PAGE_W-1:0],
						req_addr_r[OFS_W-1:0]}; // [RULE5] [RULE6]
					st_nxt = ST_IDLE;
				end
			end
		endcase
	end
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			st_r <= ST_IDLE;
			req_addr_r <= '0;
			bp_done_out <= 1'b0;
			bp_mapped_out <= 1'b0;
			bp_mem_addr_out <= '0;
			map_fetch_req_out <= 1'b0;
			map_fetch_addr_out <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			req_addr_r <= req_addr_nxt;
			bp_done_out <= done_nxt;
			bp_mapped_out <= mapped_nxt;
			bp_mem_addr_out <= mem_addr_nxt;
			map_fetch_req_out <= fetch_nxt;
			map_fetch_addr_out <= fetch_addr_nxt;
		end
	end
endmodule
`default_nettype wire

/* File: map_memory_model.sv */
// map word memory answering bridge fetches after a tag dependent delay
`default_nettype none
module map_memory_model
	import bridge_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic fetch_req_in,
	input wire logic [MEM_W-1:0] fetch_addr_in,
	output logic fetch_done_out,
	output logic [31:0] fetch_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt_r;
	logic served_r;
	logic [31:0] noise_r;
	logic [TAG_W-1:0] tag;
	// ==========================================================
	// tag bit 12 set gives an invalid word; data is noise off the strobe
	assign tag = fetch_addr_in[14:2];
	assign fetch_data_out = fetch_done_out ?
		{~tag[12], 11'h000, 7'h2a, tag} : noise_r;
	always_ff @(posedge clk_in)
	begin
		noise_r <= srst_in ? 32'ha5a5_5a5a : ~noise_r;
		fetch_done_out <= 1'b0;
		if (srst_in || !fetch_req_in)
		begin
			cnt_r <= 2'b00;
			served_r <= 1'b0;
		end
		else if (!served_r && cnt_r == tag[1:0])
		begin
			fetch_done_out <= 1'b1;
			served_r <= 1'b1;
		end
		else if (!served_r)
			cnt_r <= cnt_r + 2'b01;
	end
endmodule
`default_nettype wire

/* File: bridge_monitor.sv */
// port checker for the map cache bridge
`default_nettype none
module bridge_monitor
	import bridge_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic bp_req_in,
	input wire logic [BP_W-1:0] bp_addr_in,
	input wire logic bp_done_out,
	input wire logic bp_mapped_out,
	input wire logic [MEM_W-1:0] bp_mem_addr_out,
	input wire logic [MEM_W-1:BASE_LSB] map_base_in,
	input wire logic map_fetch_req_out,
	input wire logic [MEM_W-1:0] map_fetch_addr_out,
	input wire logic map_fetch_done_in,
	input wire logic [31:0] map_fetch_data_in,
	input wire logic cpu_req_in,
	input wire logic [31:0] cpu_addr_in,
	input wire logic cpu_ack_out,
	input wire logic [15:0] cpu_rdata_out,
	input wire logic cpu_bp_cycle_out,
	input wire logic io_page_select_out,
	input wire logic [BP_W-1:0] cpu_bp_addr_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [BP_W-1:0] req_addr_r, req_addr_nxt;
	logic comm, io_win, mem_win, req;
	logic [31:0] addr_q, data_q;
	// ==========================================================
	// decode helpers and last inbound address
	assign comm = cpu_addr_in == COMM_CPU || cpu_addr_in == COMM_DIAG;
	assign io_win = !comm && (cpu_addr_in[31:IO_LSB] == IO_CPU ||
		cpu_addr_in[31:IO_LSB] == IO_DIAG);
	assign mem_win = cpu_addr_in[31:MEMW_LSB] == MEM_CPU ||
		cpu_addr_in[31:MEMW_LSB] == MEM_DIAG;
	assign req = cpu_req_in;
	always_comb req_addr_nxt = bp_req_in ? bp_addr_in : req_addr_r;
	always_ff @(posedge clk_in)
	begin
		req_addr_r <= req_addr_nxt;
		addr_q <= cpu_addr_in;
		data_q <= map_fetch_data_in;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	property p_comm_ack;
		req && comm |=> cpu_ack_out;
	endproperty
	a_comm_ack: assert property (p_comm_ack) else $error("no ack");
	property p_rd_zero;
		cpu_ack_out |-> cpu_rdata_out[14:0] == 15'h0000;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("bits");
	property p_io_xlat;
		req && io_win |=> cpu_bp_cycle_out && io_page_select_out &&
			cpu_bp_addr_out == {9'h000, addr_q[12:0]};
	endproperty
	a_io_xlat: assert property (p_io_xlat) else $error("io");
	property p_mem_xlat;
		req && mem_win |=> cpu_bp_cycle_out && !io_page_select_out &&
			cpu_bp_addr_out == addr_q[21:0];
	endproperty
	a_mem_xlat: assert property (p_mem_xlat) else $error("mem");
	property p_no_cycle;
		!(req && (io_win || mem_win)) |=> !cpu_bp_cycle_out;
	endproperty
	a_no_cycle: assert property (p_no_cycle) else $error("cyc");
	property p_fetch_addr;
		$rose(map_fetch_req_out) |->
			map_fetch_addr_out == {map_base_in, req_addr_r[21:9], 2'b00};
	endproperty
	a_fetch_addr: assert property (p_fetch_addr) else $error("fa");
	property p_fill;
		map_fetch_req_out && map_fetch_done_in |=> bp_done_out &&
			bp_mapped_out == data_q[MAP_VALID_BIT] &&
			(!bp_mapped_out ||
			bp_mem_addr_out[28:9] == data_q[19:0]);
	endproperty
	a_fill: assert property (p_fill) else $error("fill");
	property p_offset;
		bp_done_out && bp_mapped_out |-> bp_mem_addr_out[8:0] == req_addr_r[8:0];
	endproperty
	a_offset: assert property (p_offset) else $error("ofs");
	c_hit: cover property (bp_done_out && bp_mapped_out && !map_fetch_req_out);
	c_fetch: cover property (map_fetch_done_in);
	c_io: cover property (cpu_bp_cycle_out && io_page_select_out);
endmodule
`default_nettype wire

/* File: backplane_map_cache_bridge_bench.sv */
// self-checking bench for the map cache bridge
`default_nettype none
module backplane_map_cache_bridge_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import bridge_pkg::*;
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
	logic clk_in, srst_in, dc_power_good_in, halted_in, bp_req_in;
	logic [BP_W-1:0] bp_addr_in, cpu_bp_addr_out, bp_reg_addr_in;
	logic bp_done_out, bp_mapped_out, map_fetch_req_out, map_fetch_done_in;
	logic [MEM_W-1:0] bp_mem_addr_out, map_fetch_addr_out;
	logic [MEM_W-1:BASE_LSB] map_base_in;
	logic [31:0] map_fetch_data_in, cpu_addr_in;
	logic io_reset_write_in, map_base_write_in, page_map_write_in;
	logic [TAG_W-1:0] page_map_write_tag_in;
	logic dma_error_mem_bit_in, bus_timer_expired_in, cpu_req_in, cpu_wr_in;
	logic [1:0] cpu_be_in, bp_reg_be_in;
	logic [15:0] cpu_wdata_in, cpu_rdata_out, bp_reg_wdata_in, bp_reg_rdata_out;
	logic cpu_ack_out, cpu_bp_cycle_out, io_page_select_out, f, ack, cyc;
	logic bp_reg_req_in, bp_reg_wr_in, bp_reg_ack_out;
	logic [15:0] rd;
	int bad_count, compares;
	logic [31:0] oa [5] = '{32'h1000_0123, 32'h2000_1fff, 32'h1400_0456,
		32'h303f_ffff, 32'h1000_2000};
	logic [21:0] ob [5] = '{22'h00_0123, 22'h00_1fff, 22'h00_0456,
		22'h3f_ffff, 22'h3f_ffff};
	backplane_map_cache_bridge u_backplane_map_cache_bridge (.clk_in, .srst_in,
		.dc_power_good_in, .halted_in, .bp_req_in, .bp_addr_in, .bp_done_out,
		.bp_mapped_out, .bp_mem_addr_out, .map_base_in, .map_fetch_req_out,
		.map_fetch_addr_out, .map_fetch_done_in, .map_fetch_data_in,
		.io_reset_write_in, .map_base_write_in, .page_map_write_in,
		.page_map_write_tag_in, .dma_error_mem_bit_in, .bus_timer_expired_in,
		.cpu_req_in, .cpu_wr_in, .cpu_addr_in, .cpu_be_in, .cpu_wdata_in,
		.cpu_ack_out, .cpu_rdata_out, .cpu_bp_cycle_out, .io_page_select_out,
		.cpu_bp_addr_out, .bp_reg_req_in, .bp_reg_wr_in, .bp_reg_addr_in,
		.bp_reg_be_in, .bp_reg_wdata_in, .bp_reg_ack_out, .bp_reg_rdata_out);
	map_memory_model u_map_memory_model (.clk_in, .srst_in,
		.fetch_req_in(map_fetch_req_out), .fetch_addr_in(map_fetch_addr_out),
		.fetch_done_out(map_fetch_done_in), .fetch_data_out(map_fetch_data_in));
	initial
	begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	// ==========================================================
	// access tasks
	task automatic tally_and_finish();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic acc(input logic bp, input logic wr, input logic [31:0] a,
		input logic [1:0] be, input logic [15:0] wd);
		@(posedge clk_in);
		{cpu_req_in, bp_reg_req_in, cpu_wr_in, bp_reg_wr_in} <= {!bp, bp, wr, wr};
		{cpu_addr_in, bp_reg_addr_in, cpu_be_in, bp_reg_be_in} <= {a, a[21:0], be, be};
		{cpu_wdata_in, bp_reg_wdata_in} <= {wd, wd};
		@(posedge clk_in);
		{cpu_req_in, bp_reg_req_in} <= 2'b00;
		#1;
		ack = bp ? bp_reg_ack_out : cpu_ack_out;
		rd = bp ? bp_reg_rdata_out : cpu_rdata_out;
		cyc = cpu_bp_cycle_out;
	endtask
	task automatic rdchk(input logic bp, input logic [15:0] e);
		acc(bp, 1'b0, bp ? {10'h000, COMM_BP} : COMM_CPU, 2'b11, 16'h0000);
		`CHK("comm ack", 1'b1, ack)
		`CHK("comm read", e, rd)
	endtask
	task automatic wr(input logic [1:0] be, input logic [15:0] wd);
		acc(1'b0, 1'b1, COMM_DIAG, be, wd);
		`CHK("write ack", 1'b1, ack)
	endtask
	task automatic ev(input int k);
		@(posedge clk_in);
		{io_reset_write_in, map_base_write_in} <= {k == 0, k == 1};
		{page_map_write_in, bus_timer_expired_in} <= {k == 2, k == 3};
		@(posedge clk_in);
		{io_reset_write_in, map_base_write_in} <= 2'b00;
		{page_map_write_in, bus_timer_expired_in} <= 2'b00;
	endtask
	task automatic trans(input logic [12:0] t, input logic ef, input logic [8:0] o);
		int i;
		@(posedge clk_in);
		{bp_addr_in, bp_req_in} <= {t, o, 1'b1};
		// let the done pulse of the previous request drop first
		#1;
		f = 1'b0;
		for (i = 0; i < 40 && bp_done_out !== 1'b1; i++)
		begin
			@(posedge clk_in);
			bp_req_in <= 1'b0;
			#1;
			f = f | map_fetch_req_out;
		end
		bad_count += int'(i == 40);
		if (i == 40)
			tally_and_finish();
		`CHK("fetch", ef, f)
		`CHK("mapped", ~t[12], bp_mapped_out)
		if (!t[12]) `CHK("mem addr", {7'h2a, t, o}, bp_mem_addr_out)
	endtask
	// ==========================================================
	// tests
	initial
	begin
		{srst_in, dc_power_good_in, halted_in, bp_req_in} = 4'b1100;
		{cpu_req_in, bp_reg_req_in, cpu_wr_in, bp_reg_wr_in} = 4'b0000;
		{io_reset_write_in, map_base_write_in, page_map_write_in} = 3'b000;
		{dma_error_mem_bit_in, bus_timer_expired_in} = 2'b00;
		{bp_addr_in, cpu_addr_in, bp_reg_addr_in, cpu_wdata_in} = '0;
		{bp_reg_wdata_in, cpu_be_in, bp_reg_be_in} = '0;
		{map_base_in, page_map_write_tag_in} = {14'h1234, 13'h0005};
		repeat (4) @(posedge clk_in);
		srst_in <= 1'b0;
		rdchk(1'b0, COMM_RESET);
		@(posedge clk_in);
		dma_error_mem_bit_in <= 1'b1;
		rdchk(1'b0, 16'h8000);
		rdchk(1'b1, 16'h8000);
		wr(2'b10, 16'h8000);
		rdchk(1'b0, 16'h8000);
		@(posedge clk_in);
		dma_error_mem_bit_in <= 1'b0;
		rdchk(1'b0, 16'h0000);
		ev(3);
		rdchk(1'b1, 16'h8000);
		wr(2'b10, 16'h0000);
		wr(2'b01, 16'h8000);
		rdchk(1'b0, 16'h8000);
		wr(2'b10, 16'h8000);
		rdchk(1'b0, 16'h0000);
		ev(3);
		ev(0);
		rdchk(1'b0, 16'h0000);
		ev(3);
		acc(1'b1, 1'b1, {10'h000, COMM_BP}, 2'b10, 16'h8000);
		`CHK("bp write ack", 1'b1, ack)
		rdchk(1'b1, 16'h0000);
		$display("error flag test done");
		for (int k = 0; k < 5; k++)
		begin
			acc(1'b0, 1'b0, oa[k], 2'b11, 16'h0000);
			`CHK("local ack", 1'b0, ack)
			`CHK("bp cycle", k < 4, cyc)
			`CHK("io select", k < 2, io_page_select_out)
			`CHK("bp addr", ob[k], cpu_bp_addr_out)
		end
		$display("outbound test done");
		trans(13'h0005, 1'b1, 9'h1a3);
		trans(13'h0005, 1'b0, 9'h05c);
		trans(13'h1005, 1'b1, 9'h001);
		trans(13'h1005, 1'b1, 9'h001);
		wr(2'b10, 16'h0000);
		trans(13'h0005, 1'b0, 9'h000);
		wr(2'b10, 16'h4000);
		rdchk(1'b0, 16'h0000);
		trans(13'h0005, 1'b1, 9'h000);
		for (int k = 0; k < 3; k++)
		begin
			ev(k);
			trans(13'h0005, 1'b1, 9'h000);
			trans(13'h0005, 1'b0, 9'h000);
		end
		$display("invalidate test done");
		// oldest entry goes first, whatever the pointer held before
		ev(1);
		for (int k = 0; k < 16; k++)
			trans(13'h0010 + 13'(k), 1'b1, 9'h000);
		trans(13'h0020, 1'b1, 9'h000);
		trans(13'h0011, 1'b0, 9'h000);
		trans(13'h0010, 1'b1, 9'h000);
		$display("refill order test done");
		for (int h = 0; h < 2; h++)
		begin
			ev(3);
			@(posedge clk_in);
			{halted_in, dc_power_good_in} <= {h[0], 1'b0};
			repeat (4) @(posedge clk_in);
			dc_power_good_in <= 1'b1;
			rdchk(1'b0, h[0] ? 16'h0000 : 16'h8000);
		end
		trans(13'h0012, 1'b1, 9'h000);
		@(posedge clk_in);
		srst_in <= 1'b1;
		@(posedge clk_in);
		srst_in <= 1'b0;
		// entry 0012 was just filled; only the reset can have cleared it
		trans(13'h0012, 1'b1, 9'h000);
		$display("power and reset test done");
		tally_and_finish();
	end
endmodule
bind backplane_map_cache_bridge bridge_monitor u_bridge_monitor (.clk_in,
	.srst_in, .bp_req_in, .bp_addr_in, .bp_done_out, .bp_mapped_out,
	.bp_mem_addr_out, .map_base_in, .map_fetch_req_out, .map_fetch_addr_out,
	.map_fetch_done_in, .map_fetch_data_in, .cpu_req_in, .cpu_addr_in,
	.cpu_ack_out, .cpu_rdata_out, .cpu_bp_cycle_out, .io_page_select_out,
	.cpu_bp_addr_out);
`default_nettype wire
